// *** rtl/imr_pkg.sv ***
// Constants and types of the message readout path
package imr_pkg;

	// ----------------------------------------------------------------
	// Bus address and memory map
	// ----------------------------------------------------------------
	localparam logic [6:0]  DEV_ADDR    = 7'h4b;
	localparam logic [15:0] CNT_ADDR    = 16'h0000;
	localparam logic [15:0] MSG_ADDR    = 16'h0010;
	localparam logic [15:0] INFO_BASE   = 16'h0100;
	localparam logic [15:0] INFO_LEN    = 16'h0020;
	localparam logic [15:0] INFO_LAST   = INFO_BASE + INFO_LEN - 16'h0001;

	// ----------------------------------------------------------------
	// Byte values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  INVALID_ID  = 8'hff;
	localparam logic [7:0]  SEQ_STEP    = 8'h01;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;
	localparam logic [1:0]  ICRC_LAST   = 2'h2;
	localparam logic [1:0]  WR_PTR_HI   = 2'h1;

	// ----------------------------------------------------------------
	// Checksums
	// ----------------------------------------------------------------
	localparam logic [7:0]  CRC8_POLY   = 8'h07;
	localparam logic [7:0]  CRC8_INIT   = 8'h00;
	localparam logic [23:0] CRC24_POLY  = 24'h864cfb;
	localparam logic [23:0] CRC24_INIT  = 24'h000000;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR       = 3'b011,
		ST_WR_ACK   = 3'b100,
		ST_RD       = 3'b101,
		ST_RD_ACK   = 3'b110
	} imr_bus_st_t;

	typedef enum logic [3:0] {
		PH_CNT_LO  = 4'b0000,
		PH_CNT_HI  = 4'b0001,
		PH_CNT_CRC = 4'b0010,
		PH_ID      = 4'b0011,
		PH_DATA    = 4'b0100,
		PH_SEQ     = 4'b0101,
		PH_CRC     = 4'b0110,
		PH_INFO    = 4'b0111,
		PH_ICRC    = 4'b1000,
		PH_RAW     = 4'b1001
	} imr_phase_t;

	typedef enum logic {
		CHG_EDGE  = 1'b0,
		CHG_LEVEL = 1'b1
	} imr_chg_mode_t;

endpackage : imr_pkg

// *** rtl/imr_crc_if.sv ***
// Checksum engine control and result bundle
`timescale 1ns/1ps
interface imr_crc_if #(parameter int W = 8);
	logic         clr;
	logic         en;
	logic [7:0]   data;
	logic [W-1:0] value;

	modport calc (input clr, input en, input data, output value);
	modport user (output clr, output en, output data, input value);
endinterface : imr_crc_if

// *** rtl/imr_crc.sv ***
// Byte-serial checksum engine, MSB first
`timescale 1ns/1ps
module imr_crc #(
	parameter int           W    = 8,
	parameter logic [W-1:0] POLY = '0,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Engine control
	imr_crc_if.calc   crc
);

	generate
		if (W < 8) begin : g_chk
			$error("imr_crc width below one byte");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0] val;
	} imr_crc_st_t;

	imr_crc_st_t st_q;
	imr_crc_st_t st_d;

	function automatic logic [W-1:0] crc_byte(input logic [W-1:0] c,
	                                          input logic [7:0]   d);
		logic [W-1:0] r;
		logic         fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[W-1] ^ d[i];
			r  = {r[W-2:0], 1'b0} ^ (fb ? POLY : '0);
		end
		return r;
	endfunction : crc_byte

	always_comb begin
		st_d = st_q;
		if (crc.clr) begin
			st_d.val = crc.en ? crc_byte(INIT, crc.data) : INIT;
		end else if (crc.en) begin
			st_d.val = crc_byte(st_q.val, crc.data);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.val <= INIT;
		end else begin
			st_q <= st_d;
		end
	end

	assign crc.value = st_q.val;

endmodule : imr_crc

// *** rtl/imr_readout.sv ***
// Message readout client with change line
`timescale 1ns/1ps
// Behaviour
// [RL1] Message: id, data, sequence, checksum bytes
// [RL2] Sequence starts zero, steps one, wraps
// [RL3] Message checksum over id, data, sequence
// [RL4] Identification region ends with 24-bit checksum
// [RL5] Other locations read raw, no checksum
// [RL6] Count: two bytes, checksum, then messages
// [RL7] Host sizes read as count times object
// [RL8] Host sends no START/STOP between messages
// [RL9] NACK then STOP rewinds pointer to count; code rewinds to the last written pointer (ptr_st)
// [RL10] Change line driven low when pending
// [RL11] Host reads only on change line
// [RL12] Host keeps change line an input
// [RL13] Edge or level change mode selectable
// [RL14] Edge: release after first id acknowledged
// [RL15] Edge: STOP reasserts if messages remain
// [RL16] Exhausted queue returns id 255
// [RL17] Safety host treats id 255 as error
// [RL18] Level: release after last id acknowledged
// [RL19] Level host samples line between messages
// [RL20] Software can force change line state
// [RL21] Answer only the fixed 7-bit address
// [RL22] Host reads at least one byte
// [RL23] Checksum polynomial fixed, shared with host
module imr_readout
	import imr_pkg::*;
#(
	parameter int MSG_BYTES = 8
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// Serial bus pins
	input  wire logic                   scl_i,
	input  wire logic                   sda_i,
	output wire logic                   sda_o,
	output wire logic                   sda_oe,
	// Change line pin
	output wire logic                   message_pending_line_o,
	output wire logic                   message_pending_line_oe,
	// Change line configuration
	input  wire logic                   chg_mode,
	input  wire logic                   chg_force_en,
	input  wire logic                   chg_force_low,
	input  wire logic                   resp_ready,
	// Message source
	input  wire logic [15:0]            msg_count,
	input  wire logic [7:0]             msg_id,
	input  wire logic [MSG_BYTES*8-1:0] msg_data,
	output wire logic                   msg_pop,
	// Raw memory port
	output wire logic [15:0]            raw_addr,
	input  wire logic [7:0]             raw_data
);

	generate
		if (MSG_BYTES < 1 || MSG_BYTES > 256) begin : g_chk
			$error("imr_readout MSG_BYTES out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic        scl_f;
		logic        sda_f;
		imr_bus_st_t st;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic        rw;
		logic        nack;
		logic [1:0]  wcnt;
		logic [15:0] ptr;
		logic [15:0] ptr_st;
		imr_phase_t  ph;
		imr_phase_t  ph_st;
		logic [7:0]  dcnt;
		logic [1:0]  icnt;
		logic [7:0]  seq;
		logic        live;
		logic        id_sent;
		logic        hold;
		logic        pop;
		logic        sda_oe;
		logic        chg_oe;
	} imr_st_t;

	imr_st_t st_q;
	imr_st_t st_d;

	imr_crc_if #(.W(8))  c8 ();
	imr_crc_if #(.W(24)) c24 ();

	logic       scl_n;
	logic       sda_n;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic       stage;
	logic       pend;
	logic [7:0] nb;

	function automatic imr_phase_t phase_of(input logic [15:0] a);
		if (a == CNT_ADDR)
			return PH_CNT_LO;
		if (a == MSG_ADDR)
			return PH_ID;
		if (a >= INFO_BASE && a <= INFO_LAST)
			return PH_INFO;
		return PH_RAW;
	endfunction : phase_of

	// ----------------------------------------------------------------
	// Checksum engines
	// ----------------------------------------------------------------
	imr_crc #(.W(8), .POLY(CRC8_POLY), .INIT(CRC8_INIT)) u_crc8 ( // RL23
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.crc      (c8.calc)
	);

	imr_crc #(.W(24), .POLY(CRC24_POLY), .INIT(CRC24_INIT)) u_crc24 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.crc      (c24.calc)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		st_d.pop = 1'b0;
		stage    = 1'b0;
		nb       = st_q.tx;
		c8.clr   = 1'b0;
		c8.en    = 1'b0;
		c8.data  = 8'h00;
		c24.clr  = 1'b0;
		c24.en   = 1'b0;
		c24.data = 8'h00;
		pend     = (msg_count != 16'h0000);
		// Pin filtering: second and third stage must agree
		st_d.scl_s = {st_q.scl_s[1:0], scl_i};
		st_d.sda_s = {st_q.sda_s[1:0], sda_i};
		scl_n = (st_q.scl_s[1] == st_q.scl_s[2]) ? st_q.scl_s[2] : st_q.scl_f;
		sda_n = (st_q.sda_s[1] == st_q.sda_s[2]) ? st_q.sda_s[2] : st_q.sda_f;
		st_d.scl_f = scl_n;
		st_d.sda_f = sda_n;
		rise  = scl_n & ~st_q.scl_f;
		fall  = ~scl_n & st_q.scl_f;
		start = st_q.scl_f & scl_n & st_q.sda_f & ~sda_n;
		stop  = st_q.scl_f & scl_n & ~st_q.sda_f & sda_n;

		// Bus sequencing
		if (stop) begin
			st_d.st     = ST_IDLE;
			st_d.sda_oe = 1'b0;
			st_d.ptr    = st_q.ptr_st; // RL8
			st_d.ph     = st_q.ph_st;
			st_d.hold   = 1'b0; // RL15
			st_d.wcnt   = 2'h0;
		end else if (start) begin
			st_d.st     = ST_ADDR;
			st_d.bitc   = 4'h0;
			st_d.wcnt   = 2'h0;
			st_d.sda_oe = 1'b0;
		end else begin
			case (st_q.st)
				ST_ADDR, ST_WR: begin
					if (rise) begin
						st_d.sh   = {st_q.sh[6:0], sda_n};
						st_d.bitc = st_q.bitc + 4'h1;
					end else if (fall && st_q.bitc == BYTE_BITS) begin
						st_d.bitc = 4'h0;
						if (st_q.st == ST_WR) begin
							st_d.st     = ST_WR_ACK;
							st_d.sda_oe = 1'b1;
							st_d.wcnt   = (st_q.wcnt == ICRC_LAST + 2'h1)
							            ? st_q.wcnt : st_q.wcnt + 2'h1;
							if (st_q.wcnt == 2'h0) begin
								st_d.ptr[7:0] = st_q.sh;
							end else if (st_q.wcnt == WR_PTR_HI) begin
								st_d.ptr[15:8] = st_q.sh;
								st_d.ptr_st = {st_q.sh, st_q.ptr[7:0]};
								st_d.ph     = phase_of({st_q.sh, st_q.ptr[7:0]});
								st_d.ph_st  = phase_of({st_q.sh, st_q.ptr[7:0]});
							end
						end else if (st_q.sh[7:1] == DEV_ADDR) begin // RL21
							st_d.st     = ST_ADDR_ACK;
							st_d.sda_oe = 1'b1;
							st_d.rw     = st_q.sh[0];
						end else begin
							st_d.st = ST_IDLE; // RL21
						end
					end
				end
				ST_ADDR_ACK: begin
					if (fall) begin
						st_d.sda_oe = 1'b0;
						if (st_q.rw) begin
							stage   = 1'b1;
							st_d.st = ST_RD;
						end else begin
							st_d.st = ST_WR;
						end
					end
				end
				ST_WR_ACK: begin
					if (fall) begin
						st_d.sda_oe = 1'b0;
						st_d.st     = ST_WR;
					end
				end
				ST_RD: begin
					if (fall) begin
						if (st_q.bitc == BYTE_BITS) begin
							st_d.sda_oe = 1'b0;
							st_d.st     = ST_RD_ACK;
						end else begin
							st_d.sda_oe = ~st_q.sh[7];
							st_d.sh     = {st_q.sh[6:0], 1'b0};
							st_d.bitc   = st_q.bitc + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (rise) begin
						st_d.nack = sda_n;
					end else if (fall) begin
						if (st_q.nack) begin
							st_d.st  = ST_IDLE; // RL9
							st_d.ptr = st_q.ptr_st; // RL9
							st_d.ph  = st_q.ph_st; // RL9
						end else begin
							stage   = 1'b1;
							st_d.st = ST_RD;
							if (st_q.id_sent) begin
								if (chg_mode == CHG_EDGE) begin // RL13
									st_d.hold = 1'b1; // RL14
								end else if (msg_count <= 16'h0001) begin
									st_d.hold = 1'b1; // RL18
								end
							end
						end
					end
				end
				default: begin
					st_d.st = ST_IDLE;
				end
			endcase
		end

		// Byte staging for reads
		if (stage) begin
			st_d.id_sent = 1'b0;
			case (st_q.ph)
				PH_CNT_LO: begin
					nb = msg_count[7:0]; // RL6
					c8.clr  = 1'b1;
					st_d.ph = PH_CNT_HI;
				end
				PH_CNT_HI: begin
					nb = msg_count[15:8]; // RL6
					st_d.ph = PH_CNT_CRC;
				end
				PH_CNT_CRC: begin
					nb = c8.value; // RL6
					st_d.ph = PH_ID;
				end
				PH_ID: begin
					nb = pend ? msg_id : INVALID_ID; // RL16
					c8.clr       = 1'b1;
					st_d.live    = pend;
					st_d.id_sent = pend;
					st_d.dcnt    = 8'h00;
					st_d.ph      = PH_DATA; // RL1
				end
				PH_DATA: begin
					nb = st_q.live ? msg_data[8*int'(st_q.dcnt) +: 8] : 8'h00;
					st_d.dcnt = st_q.dcnt + 8'h01;
					if (st_q.dcnt == 8'(MSG_BYTES - 1))
						st_d.ph = PH_SEQ; // RL1
				end
				PH_SEQ: begin
					nb = st_q.seq;
					st_d.ph = PH_CRC;
				end
				PH_CRC: begin
					nb = c8.value; // RL3
					if (st_q.live) begin
						st_d.pop = 1'b1;
						st_d.seq = st_q.seq + SEQ_STEP; // RL2
					end
					st_d.live = 1'b0;
					st_d.ph   = PH_ID;
				end
				PH_INFO: begin
					nb = raw_data;
					c24.clr  = (st_q.ptr == INFO_BASE);
					c24.en   = 1'b1;
					st_d.ptr = st_q.ptr + 16'h0001;
					st_d.icnt = 2'h0;
					if (st_q.ptr == INFO_LAST)
						st_d.ph = PH_ICRC;
				end
				PH_ICRC: begin
					case (st_q.icnt) // RL4
						2'h0:    nb = c24.value[23:16];
						2'h1:    nb = c24.value[15:8];
						default: nb = c24.value[7:0];
					endcase
					st_d.icnt = st_q.icnt + 2'h1;
					if (st_q.icnt == ICRC_LAST)
						st_d.ph = PH_RAW;
				end
				default: begin
					nb = raw_data; // RL5
					st_d.ptr = st_q.ptr + 16'h0001;
					st_d.ph  = PH_RAW;
				end
			endcase
			if (st_q.ph == PH_ID || st_q.ph == PH_DATA ||
			    st_q.ph == PH_SEQ || st_q.ph == PH_CNT_LO ||
			    st_q.ph == PH_CNT_HI) begin
				c8.en   = 1'b1; // RL3
				c8.data = nb;
			end
			c24.data    = nb;
			st_d.tx     = nb;
			st_d.sda_oe = ~nb[7];
			st_d.sh     = {nb[6:0], 1'b0};
			st_d.bitc   = 4'h1;
		end

		// Change line drive
		if (chg_force_en)
			st_d.chg_oe = chg_force_low; // RL20
		else
			st_d.chg_oe = (pend | resp_ready) & ~st_d.hold; // RL10
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= '0;
			st_q.scl_s <= '1;
			st_q.sda_s <= '1;
			st_q.scl_f <= 1'b1;
			st_q.sda_f <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sda_o                   = 1'b0;
	assign sda_oe                  = st_q.sda_oe;
	assign message_pending_line_o  = 1'b0;
	assign message_pending_line_oe = st_q.chg_oe;
	assign msg_pop                 = st_q.pop;
	assign raw_addr                = st_q.ptr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_id_ack;
		st_q.st == ST_RD_ACK && fall && !st_q.nack && st_q.id_sent;
	endsequence

	property p_invalid_id;
		stage && st_q.ph == PH_ID && msg_count == 16'h0000
			|=> st_q.tx == INVALID_ID && !st_q.live;
	endproperty
	a_invalid_id: assert property (p_invalid_id) // RL16
		else $error("exhausted queue did not return id 255");

	property p_seq_step;
		st_q.pop |-> st_q.seq == $past(st_q.seq) + SEQ_STEP;
	endproperty
	a_seq_step: assert property (p_seq_step) // RL2
		else $error("sequence number did not step by one");

	property p_msg_crc;
		stage && st_q.ph == PH_CRC |=> st_q.tx == $past(c8.value);
	endproperty
	a_msg_crc: assert property (p_msg_crc) // RL3
		else $error("message checksum byte wrong");

	property p_nack_rewind;
		st_q.st == ST_RD_ACK && fall && st_q.nack && !stop && !start
			|=> st_q.st == ST_IDLE && st_q.ptr == st_q.ptr_st;
	endproperty
	a_nack_rewind: assert property (p_nack_rewind) // RL9
		else $error("pointer not rewound after nack");

	property p_force;
		chg_force_en |=> message_pending_line_oe == $past(chg_force_low);
	endproperty
	a_force: assert property (p_force) // RL20
		else $error("forced change line state not applied");

	property p_edge_release;
		s_id_ack ##0 chg_mode == CHG_EDGE && !chg_force_en
			|=> st_q.hold ##1 (!message_pending_line_oe || chg_force_en);
	endproperty
	a_edge_release: assert property (p_edge_release) // RL14
		else $error("edge mode did not release after id");

	property p_level_keep;
		s_id_ack ##0 chg_mode == CHG_LEVEL && msg_count > 16'h0001
			&& !st_q.hold |=> !st_q.hold;
	endproperty
	a_level_keep: assert property (p_level_keep) // RL18
		else $error("level mode released with messages left");

	property p_stop_reassert;
		stop && msg_count != 16'h0000 && !chg_force_en
			|=> message_pending_line_oe;
	endproperty
	a_stop_reassert: assert property (p_stop_reassert) // RL15
		else $error("change line not reasserted after stop");

	sequence s_count_read;
		st_q.ph == PH_CNT_HI && st_q.tx == $past(msg_count[7:0]);
	endsequence

	property p_count_fmt;
		stage && st_q.ph == PH_CNT_LO |=> s_count_read ##0
			st_q.sda_oe == ~st_q.tx[7];
	endproperty
	a_count_fmt: assert property (p_count_fmt) // RL6
		else $error("count read out of order");

	property p_bad_addr;
		st_q.st == ST_ADDR && fall && st_q.bitc == BYTE_BITS && !stop
			&& !start && st_q.sh[7:1] != DEV_ADDR
			|=> st_q.st == ST_IDLE ##1 !st_q.sda_oe;
	endproperty
	a_bad_addr: assert property (p_bad_addr) // RL21
		else $error("foreign address answered");

	property p_raw;
		stage && st_q.ph == PH_RAW |=> st_q.tx == $past(raw_data)
			&& st_q.ph == PH_RAW;
	endproperty
	a_raw: assert property (p_raw) // RL5
		else $error("raw read altered");

	property p_info_crc;
		stage && st_q.ph == PH_ICRC && st_q.icnt == 2'h0
			|=> st_q.tx == $past(c24.value[23:16]);
	endproperty
	a_info_crc: assert property (p_info_crc) // RL4
		else $error("identification checksum byte wrong");

endmodule : imr_readout

// *** bench/imr_host.sv ***
// Host bus controller model that reads the readout client
`timescale 1ns/1ps
module imr_host
	import imr_pkg::*;
(
	// Clock
	input  wire logic core_clk,
	// Wire levels, change line only sensed
	input  wire logic sda,
	input  wire logic chg_n,
	// Open-drain pulls
	output logic      scl_oe,
	output logic      sda_oe
);
	logic [7:0] rx [0:127];
	logic       cl [0:127];
	logic [7:0] r;
	logic       a;

	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	task automatic tick();
		repeat (8) @(posedge core_clk);
	endtask : tick

	// Data moves only while the clock is low
	task automatic bit_x(input logic b, output logic s);
		repeat (2) @(posedge core_clk);
		sda_oe <= ~b;
		tick();
		scl_oe <= 1'b0;
		tick();
		s = sda;
		scl_oe <= 1'b1;
	endtask : bit_x

	// Change line sampled at the first bit of each byte
	task automatic byte_x(input logic [7:0] w, input logic b9, input int k);
		for (int i = 7; i >= 0; i--) begin
			bit_x(w[i], r[i]);
			if (i == 7) cl[k] = chg_n;
		end
		bit_x(b9, a);
		rx[k] = r;
	endtask : byte_x

	task automatic start_c();
		@(posedge core_clk);
		sda_oe <= 1'b0;
		tick();
		scl_oe <= 1'b0;
		tick();
		sda_oe <= 1'b1;
		tick();
		scl_oe <= 1'b1;
	endtask : start_c

	task automatic stop_c();
		@(posedge core_clk);
		sda_oe <= 1'b1;
		tick();
		scl_oe <= 1'b0;
		tick();
		sda_oe <= 1'b0;
		tick();
	endtask : stop_c

	task automatic set_ptr(input logic [15:0] p);
		start_c();
		byte_x({DEV_ADDR, 1'b0}, 1'b1, 127);
		byte_x(p[7:0], 1'b1, 127);
		byte_x(p[15:8], 1'b1, 127);
		stop_c();
	endtask : set_ptr

	// One frame, no break between messages, last byte refused
	task automatic rd(input int n);
		start_c();
		byte_x({DEV_ADDR, 1'b1}, 1'b1, 127);
		for (int k = 0; k < n; k++) begin
			byte_x(8'hff, k == n - 1, k);
		end
		stop_c();
	endtask : rd
endmodule : imr_host

// *** bench/tb_top.sv ***
// Self-checking bench of the message readout client
`timescale 1ns/1ps
module tb_top
	import imr_pkg::*;
();
	localparam int MB  = 4;
	localparam int OBJ = MB + 3;

	logic          core_clk, rst_n, chg_mode, chg_force_en;
	logic          chg_force_low, resp_ready, msg_pop, chg_n;
	logic          scl, sda, sda_oe, line_oe, h_scl_oe, h_sda_oe;
	logic          sda_o, line_o;
	logic [15:0]   msg_count, raw_addr;
	logic [7:0]    msg_id, raw_data, seq;
	logic [MB*8-1:0] msg_data;
	int            n_errors, n_tests;

	assign scl      = ~h_scl_oe;
	assign sda      = (sda_oe ? sda_o : 1'b1) & ~h_sda_oe;
	assign chg_n    = line_oe ? line_o : 1'b1;
	assign msg_id   = 8'h20 + msg_count[7:0];
	assign raw_data = raw_addr[7:0] ^ 8'h5a;

	always_comb begin
		for (int k = 0; k < MB; k++) begin
			msg_data[8 * k +: 8] = msg_id + 8'(k + 1);
		end
	end

	always @(posedge core_clk) begin
		if (msg_pop && msg_count != 16'h0) msg_count <= msg_count - 16'h1;
	end

	always #5 core_clk = ~core_clk;

	imr_readout #(.MSG_BYTES(MB)) imr_readout_i (
		.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .message_pending_line_o(line_o),
		.message_pending_line_oe(line_oe), .chg_mode(chg_mode),
		.chg_force_en(chg_force_en), .chg_force_low(chg_force_low),
		.resp_ready(resp_ready), .msg_count(msg_count), .msg_id(msg_id),
		.msg_data(msg_data), .msg_pop(msg_pop), .raw_addr(raw_addr),
		.raw_data(raw_data)
	);

	imr_host imr_host_i (
		.core_clk(core_clk), .sda(sda), .chg_n(chg_n),
		.scl_oe(h_scl_oe), .sda_oe(h_sda_oe)
	);

	function automatic logic [23:0] crc_up(input logic [23:0] c,
		input logic [7:0] d, input int w, input logic [23:0] p);
		logic [23:0] x;
		x = c;
		for (int i = 7; i >= 0; i--) begin
			x = (x[w - 1] ^ d[i]) ? ((x << 1) ^ p) : (x << 1);
		end
		return x & ((24'h1 << w) - 24'h1);
	endfunction : crc_up

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [23:0] e,
		input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic settle(input logic [15:0] cnt);
		msg_count <= cnt;
		repeat (4) @(posedge core_clk);
	endtask : settle

	// Reads start only once the change line is low
	task automatic wait_line();
		int i;
		i = 0;
		while (chg_n !== 1'b0 && i < 1000) begin
			@(posedge core_clk);
			i++;
		end
		if (i == 1000) begin
			n_errors++;
			$display("mismatch change line expected 0 seen %b", chg_n);
			report_and_stop();
		end
	endtask : wait_line

	task automatic chk_msg(input int b, input logic [7:0] id);
		logic [7:0]  v;
		logic [23:0] c;
		c = 24'(CRC8_INIT);
		for (int k = 0; k <= MB + 1; k++) begin
			v = (k == 0) ? id : (k > MB) ? seq : id + 8'(k);
			chk("message byte", 24'(v), 24'(imr_host_i.rx[b + k]));
			c = crc_up(c, v, 8, 24'(CRC8_POLY));
		end
		chk("message crc", c, 24'(imr_host_i.rx[b + MB + 2]));
		seq = seq + 8'h1;
	endtask : chk_msg

	task automatic sc_line();
		resp_ready <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("line on response", 24'h0, 24'(chg_n));
		resp_ready <= 1'b0;
		chg_force_en <= 1'b1;
		chg_force_low <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("line forced low", 24'h0, 24'(chg_n));
		chg_force_low <= 1'b0;
		settle(16'h2);
		chk("line forced high", 24'h1, 24'(chg_n));
		chg_force_en <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk("line on message", 24'h0, 24'(chg_n));
	endtask : sc_line

	task automatic sc_raw();
		logic [23:0] c;
		imr_host_i.set_ptr(16'h0040);
		imr_host_i.rd(2);
		for (int k = 0; k < 2; k++) begin
			chk("raw byte", 24'((8'h40 + 8'(k)) ^ 8'h5a),
				24'(imr_host_i.rx[k]));
		end
		imr_host_i.start_c();
		imr_host_i.byte_x({7'h4a, 1'b1}, 1'b1, 127);
		chk("foreign address ack", 24'h1, 24'(imr_host_i.a));
		imr_host_i.stop_c();
		c = CRC24_INIT;
		imr_host_i.set_ptr(INFO_BASE);
		imr_host_i.rd(int'(INFO_LEN) + 3);
		for (int k = 0; k < int'(INFO_LEN); k++) begin
			c = crc_up(c, 8'(k) ^ 8'h5a, 24, CRC24_POLY);
		end
		chk("info crc", c, {imr_host_i.rx[32], imr_host_i.rx[33],
			imr_host_i.rx[34]});
	endtask : sc_raw

	task automatic sc_edge();
		imr_host_i.set_ptr(MSG_ADDR);
		wait_line();
		imr_host_i.rd(OBJ);
		chk_msg(0, 8'h22);
		chk("line at id", 24'h0, 24'(imr_host_i.cl[0]));
		chk("line after id", 24'h1, 24'(imr_host_i.cl[1]));
		repeat (4) @(posedge core_clk);
		chk("count after pop", 24'h1, 24'(msg_count));
		chk("line after stop", 24'h0, 24'(chg_n));
	endtask : sc_edge

	task automatic sc_dma();
		logic [23:0] c;
		c = crc_up(24'(CRC8_INIT), 8'h01, 8, 24'(CRC8_POLY));
		c = crc_up(c, 8'h00, 8, 24'(CRC8_POLY));
		imr_host_i.set_ptr(CNT_ADDR);
		imr_host_i.rd(3 + OBJ + 1);
		chk("count", 24'h1, {8'h0, imr_host_i.rx[1], imr_host_i.rx[0]});
		chk("count crc", c, 24'(imr_host_i.rx[2]));
		chk_msg(3, 8'h21);
		chk("empty id", 24'(INVALID_ID), 24'(imr_host_i.rx[3 + OBJ]));
		repeat (4) @(posedge core_clk);
		chk("line when empty", 24'h1, 24'(chg_n));
		settle(16'h3);
		wait_line();
		imr_host_i.rd(1);
		chk("rewound count", 24'h3, 24'(imr_host_i.rx[0]));
	endtask : sc_dma

	// Byte total from the count, never from an id of 255
	task automatic sc_level();
		chg_mode <= CHG_LEVEL;
		repeat (4) @(posedge core_clk);
		wait_line();
		imr_host_i.rd(3 + 3 * OBJ);
		for (int m = 0; m < 3; m++) begin
			chk_msg(3 + m * OBJ, 8'h23 - 8'(m));
			chk("level line", 24'(m == 2),
				24'(imr_host_i.cl[4 + m * OBJ]));
		end
	endtask : sc_level

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		chg_mode = CHG_EDGE;
		chg_force_en = 1'b0;
		chg_force_low = 1'b0;
		resp_ready = 1'b0;
		msg_count = 16'h0;
		seq = 8'h0;
		n_errors = 0;
		n_tests = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk("line idle", 24'h1, 24'(chg_n));
		sc_line();
		sc_raw();
		sc_edge();
		sc_dma();
		sc_level();
		report_and_stop();
	end
endmodule : tb_top
